// ### verilog/pmc_pkg.sv
package pmc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    localparam logic [7:0] FEATURE_ENABLE_OFS = 8'h00;
    localparam logic [7:0] SOFTWARE_RESET_OFS = 8'h01;
    localparam logic [7:0] POWER_OFF_KEY_OFS = 8'h02;

    // ----------------------------------------------------------------
    // Feature enable field positions
    // ----------------------------------------------------------------
    localparam int TIMEKEEPER_ENABLE_BIT = 6;
    localparam int BACKUP_CELL_CHARGE_ENABLE_BIT = 5;
    localparam int BACKUP_VOLTAGE_COMPARE_ENABLE_BIT = 4;
    localparam int WATCHDOG_ENABLE_BIT = 3;
    localparam int WATCHDOG_EXPIRY_POWERDOWN_ENABLE_BIT = 2;
    localparam int WATCHDOG_EXPIRY_RESET_ENABLE_BIT = 1;
    localparam int COLD_RESET_FAULT_POWERDOWN_ENABLE_BIT = 0;

    // Bit 7 is not described and is kept as a plain storage bit.
    localparam logic [7:0] FEATURE_ENABLE_RESET = 8'h00;
    localparam logic [7:0] FEATURE_ENABLE_MASK = 8'hff;

    // ----------------------------------------------------------------
    // Software reset fields
    // ----------------------------------------------------------------
    localparam logic [7:0] SOFTWARE_RESET_RESET = 8'h00;
    localparam logic [7:0] SOFTWARE_RESET_MASK = 8'h03;

    // ----------------------------------------------------------------
    // Power-off key
    // ----------------------------------------------------------------
    localparam logic [7:0] POWER_OFF_KEY_VALUE = 8'ha8;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

endpackage : pmc_pkg

// ### verilog/pmc_key_if.sv
interface pmc_key_if;
    logic write_strobe;
    logic [7:0] write_data;
    logic [7:0] key_value;
    logic power_off_start;

    modport regs
    (
        output write_strobe,
        output write_data,
        input key_value,
        input power_off_start
    );

    modport checker_side
    (
        input write_strobe,
        input write_data,
        output key_value,
        output power_off_start
    );
endinterface : pmc_key_if

// ### verilog/pmc_key_check.sv
module pmc_key_check
(
    input wire logic clk_i,
    input wire logic rst_i,
    pmc_key_if.checker_side key
);

    // ----------------------------------------------------------------
    // Key compare
    // ----------------------------------------------------------------
    logic start_q;
    logic start_d;

    // The stored value never changes; the written byte is still compared.
    assign key.key_value = pmc_pkg::POWER_OFF_KEY_VALUE;

    always_comb
    begin
        start_d = key.write_strobe && (key.write_data == pmc_pkg::POWER_OFF_KEY_VALUE);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            start_q <= 1'b0;
        end
        else
        begin
            start_q <= start_d;
        end
    end

    assign key.power_off_start = start_q;

endmodule // pmc_key_check

// ### verilog/pmc_ctrl_regs.sv
// Functional notes
// - Enable bit 6 turns the timekeeper on, resets to 0 and is held on backup supply.
// - Enable bit 5 turns the backup-cell charger on, resets to 0 and is never nonvolatile.
// - Enable bit 4 switches the backup voltage comparator on with 1 and off with 0.
// - The watchdog runs only while enable bit 3 is 1, which is 0 after reset.
// - Watchdog expiry raises a reset only while enable bit 1 is 1.
// - Watchdog expiry with bit 2, or cold-reset assertion with bit 0, starts power-down.
// - The power-off key always reads 10101000; writes do not change it but are inspected.
// - Writing the power-off key with exactly its read value starts the power-off sequence.
module pmc_ctrl_regs
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic watchdog_expired_i,
    input wire logic cold_reset_input_n,
    output logic timekeeper_enable_o,
    output logic backup_cell_charge_enable_o,
    output logic backup_voltage_compare_enable_o,
    output logic watchdog_enable_o,
    output logic [1:0] software_reset_o,
    output logic watchdog_reset_o,
    output logic powerdown_start_o,
    output logic power_off_start_o
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // ----------------------------------------------------------------
    // Power-off key
    // ----------------------------------------------------------------
    // Every write to the key offset is handed over for comparison and never stored.
    pmc_key_if key ();

    pmc_key_check u_pmc_key_check
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .key(key)
    );

    assign key.write_strobe = reg_wr_i && hit(reg_addr_i, pmc_pkg::POWER_OFF_KEY_OFS);
    assign key.write_data = reg_wdata_i;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0] enable_q;
    logic [7:0] enable_d;
    logic [7:0] swrst_q;
    logic [7:0] swrst_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;

    always_comb
    begin
        enable_d = enable_q;
        swrst_d = swrst_q;
        if (reg_wr_i)
        begin
            if (hit(reg_addr_i, pmc_pkg::FEATURE_ENABLE_OFS))
            begin
                enable_d = reg_wdata_i & pmc_pkg::FEATURE_ENABLE_MASK;
            end
            else if (hit(reg_addr_i, pmc_pkg::SOFTWARE_RESET_OFS))
            begin
                swrst_d = reg_wdata_i & pmc_pkg::SOFTWARE_RESET_MASK;
            end
        end
    end

    // All enable bits clear at power-on reset, so every feature starts off.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            enable_q <= pmc_pkg::FEATURE_ENABLE_RESET;
            swrst_q <= pmc_pkg::SOFTWARE_RESET_RESET;
        end
        else
        begin
            enable_q <= enable_d;
            swrst_q <= swrst_d;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // A read and a write in the same cycle both act; the read returns the old value.
    always_comb
    begin
        rvalid_d = reg_rd_i;
        rdata_d = rdata_q;
        if (reg_rd_i)
        begin
            if (hit(reg_addr_i, pmc_pkg::FEATURE_ENABLE_OFS))
            begin
                rdata_d = enable_q;
            end
            else if (hit(reg_addr_i, pmc_pkg::SOFTWARE_RESET_OFS))
            begin
                rdata_d = swrst_q;
            end
            else if (hit(reg_addr_i, pmc_pkg::POWER_OFF_KEY_OFS))
            begin
                rdata_d = key.key_value;
            end
            else
            begin
                rdata_d = pmc_pkg::UNMAPPED_READ_VALUE;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_q <= pmc_pkg::UNMAPPED_READ_VALUE;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ----------------------------------------------------------------
    // Event outputs
    // ----------------------------------------------------------------
    logic cold_n_q;
    logic cold_n_d;
    logic wd_reset_q;
    logic wd_reset_d;
    logic pd_q;
    logic pd_d;
    logic cold_assert;
    logic wd_expiry;

    // The expiry input is ignored unless the watchdog is running.
    assign wd_expiry = watchdog_expired_i && enable_q[pmc_pkg::WATCHDOG_ENABLE_BIT];
    assign cold_assert = cold_n_q && !cold_reset_input_n;

    // ----------------------------------------------------------------
    // Cold-reset edge detect
    // ----------------------------------------------------------------
    // The history resets to the idle high level, so an input already low when reset releases counts as an assertion.
    always_comb
    begin
        cold_n_d = cold_reset_input_n;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cold_n_q <= 1'b1;
        end
        else
        begin
            cold_n_q <= cold_n_d;
        end
    end

    // ----------------------------------------------------------------
    // Event requests
    // ----------------------------------------------------------------
    always_comb
    begin
        wd_reset_d = wd_expiry
            && enable_q[pmc_pkg::WATCHDOG_EXPIRY_RESET_ENABLE_BIT];
        pd_d = (wd_expiry && enable_q[pmc_pkg::WATCHDOG_EXPIRY_POWERDOWN_ENABLE_BIT])
            || (cold_assert
            && enable_q[pmc_pkg::COLD_RESET_FAULT_POWERDOWN_ENABLE_BIT]);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wd_reset_q <= 1'b0;
            pd_q <= 1'b0;
        end
        else
        begin
            wd_reset_q <= wd_reset_d;
            pd_q <= pd_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata_o = rdata_q;
    assign reg_rvalid_o = rvalid_q;
    assign timekeeper_enable_o = enable_q[pmc_pkg::TIMEKEEPER_ENABLE_BIT];
    assign backup_cell_charge_enable_o =
        enable_q[pmc_pkg::BACKUP_CELL_CHARGE_ENABLE_BIT];
    assign backup_voltage_compare_enable_o =
        enable_q[pmc_pkg::BACKUP_VOLTAGE_COMPARE_ENABLE_BIT];
    assign watchdog_enable_o = enable_q[pmc_pkg::WATCHDOG_ENABLE_BIT];
    assign software_reset_o = swrst_q[1:0];
    assign watchdog_reset_o = wd_reset_q;
    assign powerdown_start_o = pd_q;
    assign power_off_start_o = key.power_off_start;

endmodule // pmc_ctrl_regs

// ### testbench/pmc_ctrl_regs_checker.sv
module pmc_ctrl_regs_checker
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic watchdog_expired_i,
    input wire logic cold_reset_input_n,
    input wire logic timekeeper_enable_o,
    input wire logic backup_cell_charge_enable_o,
    input wire logic backup_voltage_compare_enable_o,
    input wire logic watchdog_enable_o,
    input wire logic [1:0] software_reset_o,
    input wire logic watchdog_reset_o,
    input wire logic powerdown_start_o,
    input wire logic power_off_start_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic en_wr;
    logic key_hit;
    logic [3:0] ens;
    assign en_wr = reg_wr_i && reg_addr_i == 8'h00;
    assign key_hit = reg_wr_i && reg_addr_i == 8'h02 && reg_wdata_i == 8'ha8;
    assign ens = {timekeeper_enable_o, backup_cell_charge_enable_o,
        backup_voltage_compare_enable_o, watchdog_enable_o};
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    chk_enable_write: assert property
        (en_wr |=> ens == $past(reg_wdata_i[6:3]))
        else $error("enable bits not written");
    chk_enables_hold: assert property (!en_wr |=> $stable(ens))
        else $error("enable bits changed without a write");
    chk_wd_gated: assert property (!watchdog_enable_o |=> !watchdog_reset_o)
        else $error("reset while watchdog off");
    chk_expiry_cause: assert property (!watchdog_expired_i |=> !watchdog_reset_o)
        else $error("reset without expiry");
    chk_pd_cause: assert property
        (!watchdog_expired_i && !$fell(cold_reset_input_n) |=> !powerdown_start_o)
        else $error("power-down without cause");
    chk_key_read: assert property
        (reg_rd_i && reg_addr_i == 8'h02 |=> reg_rvalid_o && reg_rdata_o == 8'ha8)
        else $error("key read wrong");
    chk_key_start: assert property (key_hit |=> power_off_start_o)
        else $error("power-off not started");
    chk_key_quiet: assert property (!key_hit |=> !power_off_start_o)
        else $error("power-off without key");
    chk_swrst_write: assert property
        (reg_wr_i && reg_addr_i == 8'h01 |=> software_reset_o == $past(reg_wdata_i[1:0]))
        else $error("software reset bits not written");
endmodule // pmc_ctrl_regs_checker

bind pmc_ctrl_regs pmc_ctrl_regs_checker u_pmc_ctrl_regs_checker (.*);

// ### testbench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic reg_wr_i = 1'h0;
    logic reg_rd_i = 1'h0;
    logic watchdog_expired_i = 1'h0;
    logic cold_reset_input_n = 1'h1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic [1:0] software_reset_o;
    logic reg_rvalid_o, timekeeper_enable_o, backup_cell_charge_enable_o;
    logic backup_voltage_compare_enable_o, watchdog_enable_o, watchdog_reset_o;
    logic powerdown_start_o, power_off_start_o;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] en_tab [4] = '{8'h06, 8'h0e, 8'h0c, 8'h0a};

    always #25 clk_i = ~clk_i;

    pmc_ctrl_regs u_pmc_ctrl_regs (.*);

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_i);
        reg_addr_i = addr;
        reg_wdata_i = data;
        reg_wr_i = 1'h1;
        @(negedge clk_i);
        reg_wr_i = 1'h0;
    endtask

    task automatic read_reg(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge clk_i);
        reg_addr_i = addr;
        reg_rd_i = 1'h1;
        @(negedge clk_i);
        reg_rd_i = 1'h0;
        check("rvalid", 8'h01, {7'h00, reg_rvalid_o});
        check("rdata", exp, reg_rdata_o);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 400)
        begin
            fail_count++;
            complete_run();
        end
    end

    initial
    begin
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'h0;
        read_reg(8'h00, 8'h00);
        read_reg(8'h02, 8'ha8);
        read_reg(8'h7f, 8'h00);
        for (int i = 3; i < 8; i++)
        begin
            write_reg(8'h00, 8'h01 << (i % 7));
            check("enables", (8'h01 << (i % 7)) >> 3,
                {4'h0, timekeeper_enable_o, backup_cell_charge_enable_o,
                backup_voltage_compare_enable_o, watchdog_enable_o});
        end
        read_reg(8'h00, 8'h01);
        foreach (en_tab[k])
        begin
            write_reg(8'h00, en_tab[k]);
            @(negedge clk_i);
            watchdog_expired_i = 1'h1;
            @(negedge clk_i);
            watchdog_expired_i = 1'h0;
            check("wd reset", {7'h00, en_tab[k][3] & en_tab[k][1]},
                {7'h00, watchdog_reset_o});
            check("wd pd", {7'h00, en_tab[k][3] & en_tab[k][2]},
                {7'h00, powerdown_start_o});
        end
        for (int j = 0; j < 2; j++)
        begin
            write_reg(8'h00, j[7:0]);
            cold_reset_input_n = 1'h0;
            @(negedge clk_i);
            check("cold pd", j[7:0], {7'h00, powerdown_start_o});
            cold_reset_input_n = 1'h1;
        end
        write_reg(8'h02, 8'ha8);
        check("power off", 8'h01, {7'h00, power_off_start_o});
        write_reg(8'h02, 8'ha9);
        check("power off", 8'h00, {7'h00, power_off_start_o});
        read_reg(8'h02, 8'ha8);
        write_reg(8'h01, 8'hff);
        check("soft reset", 8'h03, {6'h00, software_reset_o});
        read_reg(8'h01, 8'h03);
        complete_run();
    end
endmodule // tb_top
